// file: src/dpsw_pkg.sv
// Package of offsets, field positions, reset values and types for the drive power state words
`default_nettype none
package dpsw_pkg;
  // Object indices of the register bank
  localparam logic [15:0] OFS_LAST_ERROR   = 16'h603f;
  localparam logic [15:0] OFS_COMMAND      = 16'h6040;
  localparam logic [15:0] OFS_STATE_WORD   = 16'h6041;
  localparam logic [15:0] OFS_SETPOINT     = 16'h6042;
  localparam logic [15:0] OFS_DEMAND       = 16'h6043;
  localparam logic [15:0] OFS_MEASURED     = 16'h6044;
  // Reset values
  localparam logic [15:0] RST_LAST_ERROR   = 16'h0000;
  localparam logic [15:0] RST_COMMAND      = 16'h0000;
  localparam logic [15:0] RST_STATE_WORD   = 16'h0000;
  localparam logic [15:0] RST_SETPOINT     = 16'h00c8;
  localparam logic [15:0] RST_DEMAND       = 16'h0000;
  localparam logic [15:0] RST_MEASURED     = 16'h0000;
  localparam logic [31:0] RST_VEL_MIN      = 32'h0000_0000;
  localparam logic [31:0] RST_VEL_MAX      = 32'h0000_4e20;
  // Command word bit positions
  localparam int CMD_SWITCH_ON   = 0;
  localparam int CMD_VOLTAGE     = 1;
  localparam int CMD_QUICK_N     = 2;
  localparam int CMD_RUN         = 3;
  localparam int CMD_MODE_LO     = 4;
  localparam int CMD_MODE_HI     = 6;
  localparam int CMD_FAULT_CLR   = 7;
  localparam int CMD_HALT        = 8;
  localparam int CMD_MODE_B9     = 9;
  // State word bit positions
  localparam int ST_READY    = 0;
  localparam int ST_SO       = 1;
  localparam int ST_OE       = 2;
  localparam int ST_FAULT    = 3;
  localparam int ST_POWER    = 4;
  localparam int ST_QUICK_N  = 5;
  localparam int ST_DISABLED = 6;
  localparam int ST_WARN     = 7;
  localparam int ST_SYNC     = 8;
  localparam int ST_EXTERNAL = 9;
  localparam int ST_GOAL     = 10;
  localparam int ST_LIMIT    = 11;
  localparam int ST_MODE_LO  = 12;
  localparam int ST_MODE_HI  = 13;
  localparam int ST_LOOP     = 15;
  // Operating modes that honour the halt bit
  localparam logic signed [7:0] MODE_PROFILE_POS = 8'sh01;
  localparam logic signed [7:0] MODE_VELOCITY    = 8'sh02;
  localparam logic signed [7:0] MODE_PROFILE_VEL = 8'sh03;
  localparam logic signed [7:0] MODE_PROFILE_TRQ = 8'sh04;
  localparam logic signed [7:0] MODE_INTERP_POS  = 8'sh07;
  // Power states
  typedef enum logic [2:0] {
    S_NOT_READY,
    S_SWITCH_ON_DISABLED,
    S_READY,
    S_SWITCHED_ON,
    S_OP_ENABLED,
    S_QUICK_STOP,
    S_FAULT_REACTION,
    S_FAULT
  } dpsw_state_e;
  // Register access request from the process data side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } dpsw_req_s;
  // Drive-side status reported into the block
  typedef struct packed {
    logic        init_done;
    logic        fault_event;
    logic [15:0] fault_code;
    logic        fault_clearable;
    logic        reaction_done;
    logic        stop_done;
    logic        warning;
    logic        synced;
    logic        setup_ok;
    logic        index_seen;
    logic        target_reached;
    logic        open_loop;
  } dpsw_drv_s;
endpackage
`default_nettype wire

// file: src/dpsw_fsm.sv
// Power state machine following the drive-profile transition graph
`default_nettype none
module dpsw_fsm
  import dpsw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Command inputs
  input  wire logic [15:0] cmd,
  // Drive events
  input  wire dpsw_drv_s   drv,
  // State out
  output dpsw_state_e      state
);
  dpsw_state_e next_state;
  logic        switch_req;
  logic        volt_req;
  logic        quick_n;
  logic        run_req;
  logic        clear_edge;
  logic        clear_q;

  assign switch_req = cmd[CMD_SWITCH_ON];
  assign volt_req   = cmd[CMD_VOLTAGE];
  assign quick_n    = cmd[CMD_QUICK_N];
  assign run_req    = cmd[CMD_RUN];

  // Fault clear acts on the rising edge only, so a held bit cannot loop
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      clear_q <= 1'b0;
    else
      clear_q <= cmd[CMD_FAULT_CLR];
  end
  assign clear_edge = cmd[CMD_FAULT_CLR] & ~clear_q;

  always_comb
  begin
    next_state = state;
    case (state)
      S_NOT_READY:
        if (drv.init_done)
          next_state = S_SWITCH_ON_DISABLED;
      S_SWITCH_ON_DISABLED:
        if (volt_req && quick_n && !switch_req)
          next_state = S_READY;
      S_READY:
        if (!volt_req || !quick_n)
          next_state = S_SWITCH_ON_DISABLED;
        else if (switch_req)
          next_state = (run_req) ? S_OP_ENABLED : S_SWITCHED_ON;
      S_SWITCHED_ON:
        if (!volt_req || !quick_n)
          next_state = S_SWITCH_ON_DISABLED;
        else if (!switch_req)
          next_state = S_READY;
        else if (run_req)
          next_state = S_OP_ENABLED;
      S_OP_ENABLED:
        if (!volt_req)
          next_state = S_SWITCH_ON_DISABLED;
        else if (!quick_n)
          next_state = S_QUICK_STOP;
        else if (!switch_req)
          next_state = S_READY;
        else if (!run_req)
          next_state = S_SWITCHED_ON;
      S_QUICK_STOP:
        if (!volt_req || drv.stop_done)
          next_state = S_SWITCH_ON_DISABLED;
        else if (quick_n && switch_req && run_req)
          next_state = S_OP_ENABLED;
      S_FAULT_REACTION:
        if (drv.reaction_done)
          next_state = S_FAULT;
      S_FAULT:
        if (clear_edge && drv.fault_clearable)
          next_state = S_SWITCH_ON_DISABLED;
      default:
        next_state = S_NOT_READY;
    endcase
    // A new fault overrides any operational state
    if (drv.fault_event && state != S_FAULT && state != S_FAULT_REACTION
        && state != S_NOT_READY)
      next_state = S_FAULT_REACTION;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= S_NOT_READY;
    else
      state <= next_state;
  end
endmodule
`default_nettype wire

// file: src/dpsw_top.sv
// Register bank for command, status and velocity-mode objects of a drive
`default_nettype none
// How it works
// - last error code reads, zero at reset
// - new error overwrites last error code
// - command bit 0 requests switched on
// - command bit 1 requests voltage enabled
// - command bit 2 low forces quick stop from operation enabled
// - command bit 3 requests operation enabled
// - bit 7 clears fault when clearable
// - bit 8 halts in listed modes
// - bits 4-6 and 9 mode dependent
// - not ready, disabled, fault encodings
// - ready, switched on, enabled encodings
// - quick stop and reaction encodings
// - state bits follow current state
// - disabled bit follows its state
// - sync bit follows fieldbus lock
// - remote bit always one
// - closed loop after setup and index
// - target speed writable, resets 00c8
// - speed demand read only, zero reset
// - actual speed source selectable open loop
// - clamp target, flag internal limit
module dpsw_top
(
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  // Process data access
  input  wire dpsw_pkg::dpsw_req_s   REQ,
  output logic [15:0]                RDATA,
  output logic                       RVALID,
  output logic                       RERR,
  // Drive status, same clock domain
  input  wire dpsw_pkg::dpsw_drv_s   DRV,
  input  wire logic signed [7:0]     OP_MODE,
  input  wire logic [31:0]           VEL_MIN,
  input  wire logic [31:0]           VEL_MAX,
  input  wire logic                  SPEED_SRC_ENC,
  input  wire logic signed [15:0]    SPEED_CALC,
  input  wire logic signed [15:0]    SPEED_ENC,
  // Drive control out
  output logic                       HALT,
  output logic [3:0]                 MODE_BITS,
  output logic [1:0]                 MODE_STATUS_IN_USE,
  output logic                       POWER_ON,
  output logic                       RUN,
  output logic                       QUICK_STOP,
  output logic signed [15:0]         SPEED_DEMAND
);
  import dpsw_pkg::*;

  logic [15:0]        last_error_code;
  logic [15:0]        drive_command_word;
  logic [15:0]        drive_state_word;
  logic signed [15:0] velocity_setpoint;
  logic signed [15:0] velocity_demand_value;
  logic signed [15:0] velocity_measured;
  logic               internal_limit_flag;
  logic signed [31:0] next_demand;
  logic               next_limit;
  logic signed [31:0] sp_wide;
  logic               cmd_wr;
  logic               halt_mode;
  logic [15:0]        next_state_word;
  dpsw_state_e        state;
  logic               closed_loop_ready;
  logic               quick_halt_n;
  logic               power_state;

  assign cmd_wr       = REQ.wr && REQ.index == OFS_COMMAND;
  assign quick_halt_n = drive_command_word[CMD_QUICK_N];

  // Power state machine
  dpsw_fsm u_fsm
  (
    .clk    (REF_CLK),
    .rst_b  (RST_B),
    .cmd    (drive_command_word),
    .drv    (DRV),
    .state  (state)
  );

  // Command word written by the controller; read-only objects ignore writes
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      drive_command_word <= RST_COMMAND;
    else if (cmd_wr)
      drive_command_word <= REQ.wdata;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      velocity_setpoint <= RST_SETPOINT;
    else if (REQ.wr && REQ.index == OFS_SETPOINT)
      velocity_setpoint <= REQ.wdata;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      last_error_code <= RST_LAST_ERROR;
    else if (DRV.fault_event)
      last_error_code <= DRV.fault_code;
  end

  always_comb
  begin
    sp_wide     = 32'(velocity_setpoint);
    next_demand = sp_wide;
    next_limit  = 1'b0;
    if (sp_wide < $signed(VEL_MIN))
    begin
      next_demand = $signed(VEL_MIN);
      next_limit  = 1'b1;
    end
    else if (sp_wide > $signed(VEL_MAX))
    begin
      next_demand = $signed(VEL_MAX);
      next_limit  = 1'b1;
    end
  end

  // demand follows clamped target only while running and not halted
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      velocity_demand_value <= RST_DEMAND;
      internal_limit_flag   <= 1'b0;
    end
    else
    begin
      internal_limit_flag <= next_limit;
      if (state == S_OP_ENABLED && !HALT)
        velocity_demand_value <= next_demand[15:0];
      else
        velocity_demand_value <= RST_DEMAND;
    end
  end

  // actual speed source; closed loop always uses the encoder
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      velocity_measured <= RST_MEASURED;
    else if (DRV.open_loop && !SPEED_SRC_ENC)
      velocity_measured <= SPEED_CALC;
    else
      velocity_measured <= SPEED_ENC;
  end

  assign closed_loop_ready = DRV.setup_ok && DRV.index_seen;

  // Voltage counts as applied from switched on until the machine drops out
  assign power_state = state == S_SWITCHED_ON || state == S_OP_ENABLED
                    || state == S_QUICK_STOP;

  // Every state spells out all six state bits, so each mask reads off directly
  always_comb
  begin
    next_state_word = 16'h0000;
    case (state)
      // not ready: all state bits low
      S_NOT_READY:
      begin
        next_state_word[ST_READY]    = 1'b0;
        next_state_word[ST_SO]       = 1'b0;
        next_state_word[ST_OE]       = 1'b0;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b0;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      S_SWITCH_ON_DISABLED:
      begin
        next_state_word[ST_READY]    = 1'b0;
        next_state_word[ST_SO]       = 1'b0;
        next_state_word[ST_OE]       = 1'b0;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b0;
        next_state_word[ST_DISABLED] = 1'b1;
      end
      // bit 5 set, bit 6 clear
      S_READY:
      begin
        next_state_word[ST_READY]    = 1'b1;
        next_state_word[ST_SO]       = 1'b0;
        next_state_word[ST_OE]       = 1'b0;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b1;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      S_SWITCHED_ON:
      begin
        next_state_word[ST_READY]    = 1'b1;
        next_state_word[ST_SO]       = 1'b1;
        next_state_word[ST_OE]       = 1'b0;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b1;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      S_OP_ENABLED:
      begin
        next_state_word[ST_READY]    = 1'b1;
        next_state_word[ST_SO]       = 1'b1;
        next_state_word[ST_OE]       = 1'b1;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b1;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      S_QUICK_STOP:
      begin
        next_state_word[ST_READY]    = 1'b1;
        next_state_word[ST_SO]       = 1'b1;
        next_state_word[ST_OE]       = 1'b1;
        next_state_word[ST_FAULT]    = 1'b0;
        next_state_word[ST_QUICK_N]  = 1'b0;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      // Fault reaction shows all four low bits
      S_FAULT_REACTION:
      begin
        next_state_word[ST_READY]    = 1'b1;
        next_state_word[ST_SO]       = 1'b1;
        next_state_word[ST_OE]       = 1'b1;
        next_state_word[ST_FAULT]    = 1'b1;
        next_state_word[ST_QUICK_N]  = 1'b0;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      S_FAULT:
      begin
        next_state_word[ST_READY]    = 1'b0;
        next_state_word[ST_SO]       = 1'b0;
        next_state_word[ST_OE]       = 1'b0;
        next_state_word[ST_FAULT]    = 1'b1;
        next_state_word[ST_QUICK_N]  = 1'b0;
        next_state_word[ST_DISABLED] = 1'b0;
      end
      default:
        next_state_word = 16'h0000;
    endcase
    // Voltage bit from the same state as the nibble, never a cycle behind
    next_state_word[ST_POWER]    = power_state;
    next_state_word[ST_WARN]     = DRV.warning;
    next_state_word[ST_SYNC]     = DRV.synced;
    next_state_word[ST_EXTERNAL] = 1'b1;
    // Goal flag passes straight through; limit flag comes from the registered internal_limit_flag
    next_state_word[ST_GOAL]     = DRV.target_reached;
    next_state_word[ST_LIMIT]    = internal_limit_flag;
    next_state_word[ST_MODE_HI:ST_MODE_LO] = MODE_STATUS_IN_USE;
    next_state_word[ST_LOOP]     = closed_loop_ready;
  end

  // State word register
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      drive_state_word <= RST_STATE_WORD;
    else
      drive_state_word <= next_state_word;
  end

  assign halt_mode = OP_MODE == MODE_PROFILE_POS || OP_MODE == MODE_VELOCITY
                  || OP_MODE == MODE_PROFILE_VEL || OP_MODE == MODE_PROFILE_TRQ
                  || OP_MODE == MODE_INTERP_POS;

  // Drive control outputs registered for clean timing
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      HALT               <= 1'b0;
      MODE_BITS          <= 4'h0;
      MODE_STATUS_IN_USE <= 2'h0;
      POWER_ON           <= 1'b0;
      RUN                <= 1'b0;
      QUICK_STOP         <= 1'b0;
    end
    else
    begin
      HALT <= halt_mode && drive_command_word[CMD_HALT];
      // passed on raw for the mode logic
      MODE_BITS <= {drive_command_word[CMD_MODE_B9],
                    drive_command_word[CMD_MODE_HI:CMD_MODE_LO]};
      MODE_STATUS_IN_USE <= {2{state == S_OP_ENABLED}}
                          & drive_command_word[CMD_MODE_LO+1:CMD_MODE_LO];
      POWER_ON   <= power_state;
      RUN        <= state == S_OP_ENABLED;
      QUICK_STOP <= state == S_QUICK_STOP && !quick_halt_n;
    end
  end
  assign SPEED_DEMAND = velocity_demand_value;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RDATA  <= 16'h0000;
      RVALID <= 1'b0;
      RERR   <= 1'b0;
    end
    else
    begin
      RVALID <= REQ.rd;
      RERR   <= 1'b0;
      RDATA  <= 16'h0000;
      if (REQ.rd)
      begin
        if (REQ.index == OFS_LAST_ERROR)
          RDATA <= last_error_code;
        else if (REQ.index == OFS_COMMAND)
          RDATA <= drive_command_word;
        else if (REQ.index == OFS_STATE_WORD)
          RDATA <= drive_state_word;
        else if (REQ.index == OFS_SETPOINT)
          RDATA <= velocity_setpoint;
        else if (REQ.index == OFS_DEMAND)
          RDATA <= velocity_demand_value;
        else if (REQ.index == OFS_MEASURED)
          RDATA <= velocity_measured;
        else
          RERR <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/dpsw_props.sv
// Checker of read timing, state word encoding and drive outputs
`default_nettype none
module dpsw_props
(
  // Clock and reset
  input wire logic                REF_CLK,
  input wire logic                RST_B,
  // Register access
  input wire dpsw_pkg::dpsw_req_s REQ,
  input wire logic [15:0]         RDATA,
  input wire logic                RVALID,
  input wire logic                RERR,
  // Drive side
  input wire logic signed [7:0]   OP_MODE,
  input wire logic [31:0]         VEL_MIN,
  input wire logic [31:0]         VEL_MAX,
  input wire logic                HALT,
  input wire logic                RUN,
  input wire logic                QUICK_STOP,
  input wire logic signed [15:0]  SPEED_DEMAND
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpsw_pkg::*;
  logic st_rd;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // Marks the answer cycle of a state word read
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      st_rd <= 1'b0;
    else
      st_rd <= REQ.rd && REQ.index == OFS_STATE_WORD;
  // Low state bits must match one of the documented masks
  function automatic logic enc_ok(input logic [15:0] w);
    case (w[3:0])
      4'h0: return 1'b1;
      4'h1, 4'h3: return w[6:5] == 2'b01;
      4'h7, 4'h8, 4'hf: return !w[6];
      default: return 1'b0;
    endcase
  endfunction
  property p_answer;
    REQ.rd |=> RVALID;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_quiet;
    !REQ.rd |=> !RVALID && RDATA == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_unmapped;
    REQ.rd && !(REQ.index inside {[OFS_LAST_ERROR:OFS_MEASURED]}) |=> RERR && RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped;
    REQ.rd && REQ.index inside {[OFS_LAST_ERROR:OFS_MEASURED]} |=> !RERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read refused");
  property p_rem;
    st_rd |-> RDATA[ST_EXTERNAL];
  endproperty
  a_rem: assert property (p_rem) else $error("remote bit low");
  property p_enc;
    st_rd |-> enc_ok(RDATA);
  endproperty
  a_enc: assert property (p_enc) else $error("bad state encoding");
  property p_halt;
    HALT |-> $past(OP_MODE) inside {8'sh01, 8'sh02, 8'sh03, 8'sh04, 8'sh07};
  endproperty
  a_halt: assert property (p_halt) else $error("halt in wrong mode");
  property p_clamp;
    SPEED_DEMAND != 16'sh0000 |-> RUN && $signed(VEL_MIN) <= SPEED_DEMAND
      && SPEED_DEMAND <= $signed(VEL_MAX);
  endproperty
  a_clamp: assert property (p_clamp) else $error("demand outside limits");
  property p_excl;
    QUICK_STOP |-> !RUN;
  endproperty
  a_excl: assert property (p_excl) else $error("quick stop while running");
  // Main scenarios
  c_enabled: cover property (st_rd && RDATA[6:0] == 7'h37);
  c_halt: cover property (HALT);
  c_refused: cover property (RERR);
  c_quick: cover property (QUICK_STOP);
endmodule
bind dpsw_top dpsw_props chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .REQ(REQ), .RDATA(RDATA),
  .RVALID(RVALID), .RERR(RERR), .OP_MODE(OP_MODE), .VEL_MIN(VEL_MIN), .VEL_MAX(VEL_MAX),
  .HALT(HALT), .RUN(RUN), .QUICK_STOP(QUICK_STOP), .SPEED_DEMAND(SPEED_DEMAND));
`default_nettype wire

// file: tb/dpsw_master.sv
// Process data master model issuing register requests
`default_nettype none
module dpsw_master
(
  // Clock
  input wire logic                clk,
  // Requests and answers
  output var dpsw_pkg::dpsw_req_s req,
  input wire logic [15:0]         rdata,
  input wire logic                rvalid,
  input wire logic                rerr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpsw_pkg::*;
  initial req = '0;
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  // Read strobe, answer looked at once settled; bounded wait
  task automatic rd(input logic [15:0] idx, output logic [15:0] d, output logic e,
                    output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    e = 1'b0;
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(negedge clk);
      if (rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = rdata;
        e = rerr;
      end
    end
    // Hand back on a rising edge so callers drive inputs there
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_drive_power_state_words.sv
// Self-checking bench for the drive power state word register bank
`default_nettype none
module tb_drive_power_state_words;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsw_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  dpsw_req_s         req;
  logic [15:0]       rdata;
  logic              rvalid;
  logic              rerr;
  dpsw_drv_s         drv = '0;
  logic signed [7:0] op_mode = 8'sh02;
  logic [31:0]       vel_min = RST_VEL_MIN;
  logic [31:0]       vel_max = RST_VEL_MAX;
  logic              src_enc = 1'b0;
  logic signed [15:0] spd_calc = 16'sh0123;
  logic signed [15:0] spd_enc = 16'sh0456;
  logic              halt;
  logic [3:0]        mode_bits;
  logic [1:0]        mode_st;
  logic              power_on;
  logic              run;
  logic              quick;
  logic signed [15:0] demand;
  int                fail_count = 0;
  int                checks_done = 0;
  logic [15:0]       v;
  logic              e;
  logic              ok;
  // 40 MHz reference clock
  always #12.5 ref_clk = ~ref_clk;
  dpsw_top dut (.REF_CLK(ref_clk), .RST_B(rst_b), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .RERR(rerr), .DRV(drv), .OP_MODE(op_mode), .VEL_MIN(vel_min), .VEL_MAX(vel_max),
    .SPEED_SRC_ENC(src_enc), .SPEED_CALC(spd_calc), .SPEED_ENC(spd_enc), .HALT(halt),
    .MODE_BITS(mode_bits), .MODE_STATUS_IN_USE(mode_st), .POWER_ON(power_on), .RUN(run),
    .QUICK_STOP(quick), .SPEED_DEMAND(demand));
  dpsw_master m (.clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid), .rerr(rerr));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read an object and compare the masked value; a lost answer ends the run
  task automatic rdc(input logic [15:0] idx, input logic [15:0] msk, input logic [15:0] exp,
                     input string what);
    m.rd(idx, v, e, ok);
    if (!ok)
    begin
      fail_count++;
      results();
    end
    else
      chk(v & msk, exp, what);
  endtask
  // State word lags a write by three cycles, so four are allowed
  task automatic wt();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic cw(input logic [15:0] d);
    m.wr(OFS_COMMAND, d);
    wt();
  endtask
  task automatic fault(input logic [15:0] code);
    @(posedge ref_clk);
    drv.fault_code <= code;
    drv.fault_event <= 1'b1;
    @(posedge ref_clk);
    drv.fault_event <= 1'b0;
    wt();
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(OFS_LAST_ERROR, 16'hffff, RST_LAST_ERROR, "error reset");
    rdc(OFS_COMMAND, 16'hffff, RST_COMMAND, "command reset");
    rdc(OFS_SETPOINT, 16'hffff, RST_SETPOINT, "setpoint reset");
    rdc(OFS_DEMAND, 16'hffff, RST_DEMAND, "demand reset");
    rdc(16'h6045, 16'hffff, 16'h0000, "unmapped");
    chk({15'h0000, e}, 16'h0001, "refusal");
    m.wr(OFS_DEMAND, 16'h1111);
    rdc(OFS_DEMAND, 16'hffff, 16'h0000, "read-only demand");
    @(posedge ref_clk);
    drv.init_done <= 1'b1;
    wt();
    rdc(OFS_STATE_WORD, 16'h024f, 16'h0240, "disabled");
    cw(16'h0006);
    rdc(OFS_STATE_WORD, 16'h006f, 16'h0021, "ready");
    cw(16'h0007);
    rdc(OFS_STATE_WORD, 16'h006f, 16'h0023, "switched on");
    chk({15'h0000, power_on}, 16'h0001, "power on");
    cw(16'h000f);
    rdc(OFS_STATE_WORD, 16'h086f, 16'h0027, "enabled");
    chk({15'h0000, run}, 16'h0001, "run");
    rdc(OFS_DEMAND, 16'hffff, 16'h00c8, "demand");
    chk(demand, 16'h00c8, "demand output");
    m.wr(OFS_SETPOINT, 16'h7fff);
    wt();
    rdc(OFS_SETPOINT, 16'hffff, 16'h7fff, "setpoint");
    rdc(OFS_DEMAND, 16'hffff, 16'h4e20, "upper clamp");
    rdc(OFS_STATE_WORD, 16'h0800, 16'h0800, "limit high");
    m.wr(OFS_SETPOINT, 16'hff00);
    wt();
    rdc(OFS_DEMAND, 16'hffff, 16'h0000, "lower clamp");
    rdc(OFS_STATE_WORD, 16'h0800, 16'h0800, "limit low");
    m.wr(OFS_SETPOINT, 16'h0100);
    wt();
    rdc(OFS_STATE_WORD, 16'h0800, 16'h0000, "no limit");
    cw(16'h010f);
    chk({15'h0000, halt}, 16'h0001, "halt");
    rdc(OFS_DEMAND, 16'hffff, 16'h0000, "halted demand");
    @(posedge ref_clk);
    op_mode <= 8'sh05;
    wt();
    chk({15'h0000, halt}, 16'h0000, "halt other mode");
    @(posedge ref_clk);
    op_mode <= 8'sh02;
    cw(16'h025f);
    chk({12'h000, mode_bits}, 16'h000d, "mode bits");
    rdc(OFS_STATE_WORD, 16'h3000, 16'h1000, "mode status");
    chk({14'h0000, mode_st}, 16'h0001, "mode status output");
    cw(16'h000b);
    rdc(OFS_STATE_WORD, 16'h006f, 16'h0007, "quick stop");
    chk({15'h0000, quick}, 16'h0001, "quick output");
    cw(16'h000f);
    rdc(OFS_STATE_WORD, 16'h006f, 16'h0027, "re-enabled");
    @(posedge ref_clk);
    drv.synced <= 1'b1;
    wt();
    rdc(OFS_STATE_WORD, 16'h0100, 16'h0100, "sync");
    drv.synced <= 1'b0;
    wt();
    rdc(OFS_STATE_WORD, 16'h0100, 16'h0000, "no sync");
    drv.setup_ok <= 1'b1;
    wt();
    rdc(OFS_STATE_WORD, 16'h8000, 16'h0000, "no index");
    drv.index_seen <= 1'b1;
    wt();
    rdc(OFS_STATE_WORD, 16'h8000, 16'h8000, "closed loop");
    drv.open_loop <= 1'b1;
    wt();
    rdc(OFS_MEASURED, 16'hffff, 16'h0123, "calculated speed");
    src_enc <= 1'b1;
    wt();
    rdc(OFS_MEASURED, 16'hffff, 16'h0456, "encoder speed");
    fault(16'h1234);
    rdc(OFS_STATE_WORD, 16'h004f, 16'h000f, "reaction");
    rdc(OFS_LAST_ERROR, 16'hffff, 16'h1234, "error code");
    drv.reaction_done <= 1'b1;
    wt();
    rdc(OFS_STATE_WORD, 16'h004f, 16'h0008, "fault");
    drv.reaction_done <= 1'b0;
    cw(16'h0080);
    rdc(OFS_STATE_WORD, 16'h004f, 16'h0008, "fault kept");
    cw(16'h0000);
    drv.fault_clearable <= 1'b1;
    cw(16'h0080);
    rdc(OFS_STATE_WORD, 16'h004f, 16'h0040, "fault cleared");
    fault(16'h5678);
    rdc(OFS_LAST_ERROR, 16'hffff, 16'h5678, "newest error");
    results();
  end
endmodule
`default_nettype wire
